// *** dv/plsw_chk_sva.sv ***
/* Port checker of the PLL setup and wait block.
   Assumes it is bound to plsw_top and sees its one clock. */
`timescale 1ns/1ps
`default_nettype none
module plsw_chk
	import plsw_pkg::*;
#(
	parameter bit FIRST_VARIANT = 1'b0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic soft_resetn,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic loop_enable,
	input wire plsw_cfg_t loop_cfg,
	input wire logic loop_stable,
	input wire logic irq
);
	// One clock, full reset disables all checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Steps of the wait start and the status clear
	sequence sq_start;
		$rose(loop_enable);
	endsequence
	sequence sq_clear;
		reg_wr && reg_addr == 5'h14 && reg_wdata[2] && loop_stable;
	endsequence
	chk_wait_resv: assert property (reg_rd && reg_addr == 5'h00
		|=> reg_rdata[7:5] == 3'h0 && !reg_rdata[3])
		else $error("wait register reserved bits set");
	chk_ref_write: assert property (reg_wr && reg_addr == 5'h00
		|=> loop_cfg.ref_select == $past(reg_wdata[4]))
		else $error("reference select not taken");
	chk_ratio_write: assert property (reg_wr && reg_addr == 5'h04
		|=> {loop_cfg.reference_divider, loop_cfg.vco_divider}
		== $past(reg_wdata))
		else $error("divide ratios not taken");
	chk_fb_refuse: assert property (!FIRST_VARIANT && reg_wr
		&& reg_addr == 5'h08 && reg_wdata[5:0] >= 6'h32
		|=> $stable(loop_cfg.feedback_divider))
		else $error("prohibited feedback code stored");
	chk_enable_hold: assert property (sq_start
		|=> !loop_stable [*8])
		else $error("wait ended too early");
	chk_stable_drop: assert property (!loop_enable |=> !loop_stable)
		else $error("stable without loop enable");
	chk_soft_keep: assert property (!soft_resetn && !reg_wr
		|=> $stable(loop_cfg))
		else $error("configuration lost at software reset");
	chk_irq_cause: assert property ($rose(irq)
		|-> $past(loop_stable) || $past(reg_wr))
		else $error("interrupt without cause");
	chk_clr_irq: assert property (sq_clear |=> !irq)
		else $error("interrupt kept after clear");
endmodule // plsw_chk
`default_nettype wire

// *** dv/plsw_tb.sv ***
/* Self-checking bench of the PLL setup and wait block.
   Assumes design files and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb
	import plsw_pkg::*;
;
	typedef struct packed {
		logic [4:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} plsw_row_t;
	logic clk = 1'b0;
	logic resetn, soft_resetn, reg_wr, reg_rd, loop_enable, rc, xtal;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [3:0] ph = 4'h0;
	plsw_cfg_t loop_cfg;
	logic ref_tick, vco_out_tick, feedback_tick, loop_stable, irq;
	int errors = 0, tests_run = 0;
	plsw_row_t rows [10] = '{'{5'h00, 8'hFF, 8'h17}, '{5'h04, 8'hA5, 8'hA5},
		'{5'h08, 8'hFF, 8'h00}, '{5'h08, 8'h31, 8'h31},
		'{5'h08, 8'h72, 8'h31}, '{5'h0C, 8'hFF, 8'h04},
		'{5'h0C, 8'h00, 8'h00}, '{5'h10, 8'hFF, 8'h00},
		'{5'h14, 8'hFF, 8'h00}, '{5'h1C, 8'hFF, 8'h00}};

	// Clock and slow source clocks: rc period 4, crystal period 6
	always #2 clk = ~clk;
	always @(posedge clk) ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
	assign rc = ph[1:0] < 2'h2;
	assign xtal = (ph % 4'h6) < 4'h3;

	plsw_top uut (.clk(clk), .resetn(resetn), .soft_resetn(soft_resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_enable(loop_enable),
		.main_crystal_clock(xtal), .fast_rc_clock(rc), .vco_clock(rc),
		.loop_cfg(loop_cfg), .ref_tick(ref_tick),
		.vco_out_tick(vco_out_tick), .feedback_tick(feedback_tick),
		.loop_stable(loop_stable), .irq(irq));

	// Compare and report
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask
	// Cycles between second and third tick of one divider output
	task automatic gap(input int i, input int e);
		int t, n;
		logic [2:0] tk;
		n = 0;
		t = 0;
		for (int k = 0; k < 800 && n < 3; k++) begin
			@(posedge clk);
			tk = {ref_tick, vco_out_tick, feedback_tick};
			if (tk[i]) begin
				n++;
				t = (n == 3) ? k - t : k;
			end
		end
		chk("tick_gap", e, t);
	endtask
	// One full wait, counting rc rises until stable
	task automatic run_wait(input logic [2:0] c, input logic ien);
		int n;
		logic p;
		wr(5'h00, {5'h00, c});
		wr(5'h0C, {5'h00, ien, 2'h0});
		@(posedge clk);
		loop_enable <= 1'b1;
		@(posedge clk);
		n = 0;
		p = rc;
		for (int k = 0; k < 40000 && !loop_stable; k++) begin
			@(posedge clk);
			if (rc && !p) n++;
			p = rc;
		end
		chk("rc_rises", 32'h1 << (9 + c), n);
		#1 chk("irq", ien, irq);
		rd(5'h10, 8'h04);
		wr(5'h14, 8'h04);
		rd(5'h10, 8'h00);
		chk("irq", 0, irq);
		@(posedge clk);
		loop_enable <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("loop_stable", 0, loop_stable);
	endtask
	task give_verdict;
		if (errors == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		resetn = 1'b0;
		soft_resetn = 1'b1;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		loop_enable = 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 3; i++) rd(5'(i * 4), 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		wr(5'h04, 8'h21);
		wr(5'h08, 8'h02);
		wr(5'h00, 8'h00);
		gap(2, 18);
		gap(1, 8);
		gap(0, 12);
		wr(5'h00, 8'h10);
		gap(2, 12);
		wr(5'h00, 8'h11);
		wr(5'h0C, 8'h04);
		@(posedge clk);
		soft_resetn <= 1'b0;
		repeat (3) @(posedge clk);
		soft_resetn <= 1'b1;
		rd(5'h00, 8'h11);
		rd(5'h04, 8'h21);
		rd(5'h08, 8'h02);
		rd(5'h0C, 8'h00);
		for (int c = 0; c < 3; c++) run_wait(3'(c), c != 0);
		wr(5'h00, 8'h00);
		@(posedge clk);
		loop_enable <= 1'b1;
		repeat (100) @(posedge clk);
		loop_enable <= 1'b0;
		repeat (3000) @(posedge clk);
		rd(5'h10, 8'h00);
		give_verdict;
	end

	// Watchdog well beyond the expected run
	initial begin
		#160000;
		errors++;
		give_verdict;
	end
endmodule // tb

bind plsw_top plsw_chk #(.FIRST_VARIANT(FIRST_VARIANT)) chk_i (.clk,
	.resetn, .soft_resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .loop_enable, .loop_cfg, .loop_stable, .irq);
`default_nettype wire

// *** logic/plsw_edge_div.sv ***
/*
 * Divides a stream of one-cycle ticks by ratio plus one.
 * Assumes ticks are single-cycle pulses synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module plsw_edge_div #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic tick_in,
	input wire logic [W-1:0] ratio,
	output logic tick_out
);
	logic [W-1:0] cnt_q;
	logic tick_q;

	// Count input ticks, wrap at the ratio
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
		end else if (tick_in) begin
			if (cnt_q >= ratio) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// One output tick per wrap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_in && (cnt_q >= ratio);
		end
	end

	assign tick_out = tick_q;
endmodule // plsw_edge_div
`default_nettype wire

// *** logic/plsw_map.svh ***
/*
 * Register offsets, field positions, reset values and counts of the PLL
 * setup and stabilization wait block.
 * Assumes an 8-bit register port with a 5-bit byte address.
 */
// Functional notes
// (RL1) Bit 4 of wait register picks crystal (0, reset) or fast RC reference (1).
// (RL2) Bits 2:0 pick a wait of 2^(9+code) fast RC periods.
// (RL3) Software sets the wait code before raising the loop enable.
// (RL4) Rewriting the wait code mid-wait leaves that wait length unguaranteed.
// (RL5) Wait and feedback divider registers survive software reset.
// (RL6) Bits 7:4 of divider register divide the reference by value plus one.
// (RL7) Bits 3:0 of divider register divide the VCO output by value plus one.
// (RL8) Software sets input and VCO ratios before raising the loop enable.
// (RL9) First variant: 5-bit feedback field 4:0, divide 1 to 32, reset zero.
// (RL10) Other variants: 6-bit field 5:0, divide 1 to 50, codes 50-63 prohibited.
// (RL11) Software sets the feedback ratio before raising the loop enable.
// (RL12) Reserved bits read zero; software writes them as zero.
// (RL13) Wait completion sets status bit 2, which reads zero until then.
// (RL14) Completion raises the interrupt only while enable bit 2 is one.
// (RL15) Counter restarts on each rise of loop enable, flags done at the count.
// (RL16) Divider fields statically divide reference, VCO and feedback paths.
`ifndef PLSW_MAP_SVH
`define PLSW_MAP_SVH

// Byte addresses of the registers
`define PLSW_OFS_WAIT 5'h00
`define PLSW_OFS_DIVS 5'h04
`define PLSW_OFS_FBDIV 5'h08
`define PLSW_OFS_IRQ_EN 5'h0C
`define PLSW_OFS_IRQ_STAT 5'h10
`define PLSW_OFS_IRQ_CLR 5'h14

// Field positions
`define PLSW_REFSEL_BIT 4
`define PLSW_WAIT_HI 2
`define PLSW_KDIV_HI 7
`define PLSW_KDIV_LO 4
`define PLSW_MDIV_HI 3
`define PLSW_NDIV_NARROW_HI 4
`define PLSW_NDIV_WIDE_HI 5
`define PLSW_DONE_BIT 2

// Reset values and limits
`define PLSW_RST_BYTE 8'h00
`define PLSW_RST_WAIT 3'h0
`define PLSW_RST_DIV4 4'h0
`define PLSW_RST_NDIV 6'h00
`define PLSW_NDIV_FIRST_BAD 6'h32
`define PLSW_WAIT_BASE_EXP 5'h09

`endif

// *** logic/plsw_pkg.sv ***
/*
 * Types of the PLL setup and stabilization wait block.
 * Assumes plsw_map.svh for the numbers that size nothing here.
 */
package plsw_pkg;

	// Static loop configuration handed to the loop
	typedef struct packed {
		logic ref_select;
		logic [3:0] reference_divider;
		logic [3:0] vco_divider;
		logic [5:0] feedback_divider;
	} plsw_cfg_t;

	// Register port request
	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} plsw_req_t;

	// Wait timer state
	typedef enum logic [1:0] {
		PLSW_IDLE = 2'b00,
		PLSW_COUNT = 2'b01,
		PLSW_DONE = 2'b10
	} plsw_wait_state_t;

endpackage

// *** logic/plsw_top.sv ***
/*
 * PLL reference select, divide ratios and stabilization wait, with
 * registers, completion status and interrupt.
 * Assumes clock levels on its inputs are already synchronous to clk
 * and slow against it, and that software reset arrives as a level.
 */
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "plsw_map.svh"
module plsw_top
	import plsw_pkg::*;
#(
	parameter bit FIRST_VARIANT = 1'b0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic soft_resetn,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic loop_enable,
	input wire logic main_crystal_clock,
	input wire logic fast_rc_clock,
	input wire logic vco_clock,
	output plsw_cfg_t loop_cfg,
	output logic ref_tick,
	output logic vco_out_tick,
	output logic feedback_tick,
	output logic loop_stable,
	output logic irq
);
	plsw_req_t req;
	plsw_cfg_t cfg_q;
	logic [2:0] wait_sel_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic irq_en_q;
	logic done_status_q;
	logic soft_clr;
	logic loop_en_q;
	logic loop_start;
	logic rc_q;
	logic rc_tick;
	logic ref_level;
	logic ref_q;
	logic ref_raw_tick;
	logic vco_q;
	logic vco_raw_tick;
	logic fb_raw_tick;
	logic wait_done;
	logic [5:0] ndiv_wr;
	logic ndiv_ok;

	// Rising edge of a sampled level
	function automatic logic rise(input logic prev, input logic cur);
		rise = cur && !prev;
	endfunction

	// Decode one register address
	function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
		hit = (a == ofs);
	endfunction

	// Bundle the register port
	assign req.addr = reg_addr;
	assign req.wdata = reg_wdata;
	assign req.wr = reg_wr;
	assign req.rd = reg_rd;
	assign soft_clr = !soft_resetn;

	// Feedback code as the variant lets it be stored
	always_comb begin
		if (FIRST_VARIANT) begin
			ndiv_wr = {1'b0, req.wdata[`PLSW_NDIV_NARROW_HI:0]}; // [RL9]
			ndiv_ok = 1'b1;
		end else begin
			ndiv_wr = req.wdata[`PLSW_NDIV_WIDE_HI:0];
			ndiv_ok = (ndiv_wr < `PLSW_NDIV_FIRST_BAD); // [RL10]
		end
	end

	// Wait and reference select: only a full reset clears them [RL5]
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q.ref_select <= 1'b0; // [RL1]
			wait_sel_q <= `PLSW_RST_WAIT; // [RL2]
		end else if (req.wr && hit(req.addr, `PLSW_OFS_WAIT)) begin
			cfg_q.ref_select <= req.wdata[`PLSW_REFSEL_BIT]; // [RL1]
			wait_sel_q <= req.wdata[`PLSW_WAIT_HI:0]; // [RL2] [RL4]
		end
	end

	// Input and VCO ratios
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q.reference_divider <= `PLSW_RST_DIV4; // [RL6]
			cfg_q.vco_divider <= `PLSW_RST_DIV4; // [RL7]
		end else if (req.wr && hit(req.addr, `PLSW_OFS_DIVS)) begin
			cfg_q.reference_divider <=
				req.wdata[`PLSW_KDIV_HI:`PLSW_KDIV_LO]; // [RL6]
			cfg_q.vco_divider <= req.wdata[`PLSW_MDIV_HI:0]; // [RL7]
		end
	end

	// Feedback ratio; survives software reset, prohibited codes dropped
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q.feedback_divider <= `PLSW_RST_NDIV; // [RL9] [RL10]
		end else if (req.wr && hit(req.addr, `PLSW_OFS_FBDIV) && ndiv_ok) begin
			cfg_q.feedback_divider <= ndiv_wr; // [RL5] [RL10]
		end
	end

	// Interrupt enable; cleared by either reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_en_q <= 1'b0; // [RL14]
		end else if (soft_clr) begin
			irq_en_q <= 1'b0;
		end else if (req.wr && hit(req.addr, `PLSW_OFS_IRQ_EN)) begin
			irq_en_q <= req.wdata[`PLSW_DONE_BIT]; // [RL14]
		end
	end

	// Sticky completion status; a completion wins over a clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			done_status_q <= 1'b0; // [RL13]
		end else if (soft_clr) begin
			done_status_q <= 1'b0;
		end else if (wait_done) begin
			done_status_q <= 1'b1; // [RL13]
		end else if (req.wr && hit(req.addr, `PLSW_OFS_IRQ_CLR) &&
				req.wdata[`PLSW_DONE_BIT]) begin
			done_status_q <= 1'b0;
		end
	end

	// Level interrupt while enabled status is set
	assign irq = done_status_q && irq_en_q; // [RL14]

	// Read mux; reserved bits and unmapped addresses read zero
	always_comb begin
		rdata_d = `PLSW_RST_BYTE;
		if (hit(req.addr, `PLSW_OFS_WAIT)) begin
			rdata_d[`PLSW_REFSEL_BIT] = cfg_q.ref_select; // [RL12]
			rdata_d[`PLSW_WAIT_HI:0] = wait_sel_q;
		end else if (hit(req.addr, `PLSW_OFS_DIVS)) begin
			rdata_d[`PLSW_KDIV_HI:`PLSW_KDIV_LO] = cfg_q.reference_divider;
			rdata_d[`PLSW_MDIV_HI:0] = cfg_q.vco_divider;
		end else if (hit(req.addr, `PLSW_OFS_FBDIV)) begin
			rdata_d[`PLSW_NDIV_WIDE_HI:0] = cfg_q.feedback_divider; // [RL12]
		end else if (hit(req.addr, `PLSW_OFS_IRQ_EN)) begin
			rdata_d[`PLSW_DONE_BIT] = irq_en_q;
		end else if (hit(req.addr, `PLSW_OFS_IRQ_STAT)) begin
			rdata_d[`PLSW_DONE_BIT] = done_status_q; // [RL13]
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= `PLSW_RST_BYTE;
		end else if (req.rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= `PLSW_RST_BYTE;
		end
	end

	assign reg_rdata = rdata_q;

	// Previous levels for edge detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			loop_en_q <= 1'b0;
			rc_q <= 1'b0;
			ref_q <= 1'b0;
			vco_q <= 1'b0;
		end else begin
			loop_en_q <= loop_enable;
			rc_q <= fast_rc_clock;
			ref_q <= ref_level;
			vco_q <= vco_clock;
		end
	end

	// Reference mux; a select change may give one stray edge
	assign ref_level = cfg_q.ref_select ? fast_rc_clock
		: main_crystal_clock; // [RL1]
	assign ref_raw_tick = rise(ref_q, ref_level);
	assign rc_tick = rise(rc_q, fast_rc_clock);
	assign loop_start = rise(loop_en_q, loop_enable); // [RL15]
	assign vco_raw_tick = rise(vco_q, vco_clock);

	// Feedback path is taken from the VCO itself
	assign fb_raw_tick = vco_raw_tick;

	// Stabilization wait
	plsw_wait_timer u_wait (
		.clk(clk),
		.resetn(resetn),
		.soft_clr(soft_clr),
		.start(loop_start),
		.enable(loop_enable),
		.rc_tick(rc_tick),
		.wait_sel(wait_sel_q),
		.done_pulse(wait_done),
		.stable(loop_stable)
	);

	// Reference divided by the input ratio
	plsw_edge_div #(.W(4)) u_ref_div (
		.clk(clk),
		.resetn(resetn),
		.tick_in(ref_raw_tick),
		.ratio(cfg_q.reference_divider),
		.tick_out(ref_tick)
	); // [RL6] [RL16]

	// VCO output divided by the VCO ratio
	plsw_edge_div #(.W(4)) u_vco_div (
		.clk(clk),
		.resetn(resetn),
		.tick_in(vco_raw_tick),
		.ratio(cfg_q.vco_divider),
		.tick_out(vco_out_tick)
	); // [RL7] [RL16]

	// Feedback path divided by the feedback ratio
	plsw_edge_div #(.W(6)) u_fb_div (
		.clk(clk),
		.resetn(resetn),
		.tick_in(fb_raw_tick),
		.ratio(cfg_q.feedback_divider),
		.tick_out(feedback_tick)
	); // [RL9] [RL10] [RL16]

	// Static configuration to the loop
	assign loop_cfg = cfg_q; // [RL16]
endmodule // plsw_top
`default_nettype wire

// *** logic/plsw_wait_timer.sv ***
/*
 * Stabilization wait counter, counted in fast RC clock periods.
 * Assumes rc_tick pulses once per fast RC period and start once per
 * rising edge of the loop enable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "plsw_map.svh"
module plsw_wait_timer
	import plsw_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic soft_clr,
	input wire logic start,
	input wire logic enable,
	input wire logic rc_tick,
	input wire logic [2:0] wait_sel,
	output logic done_pulse,
	output logic stable
);
	plsw_wait_state_t state_q;
	logic [16:0] cnt_q;
	logic done_q;

	// Periods to wait for a code: 2^(base + code)
	function automatic logic [16:0] wait_len(input logic [2:0] code);
		logic [4:0] exp_v;
		exp_v = `PLSW_WAIT_BASE_EXP + {2'b00, code};
		wait_len = 17'h00001 << exp_v;
	endfunction

	// Count while enabled; code is read live, so a rewrite skews it [RL4]
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= PLSW_IDLE;
			cnt_q <= '0;
		end else if (soft_clr || !enable) begin
			state_q <= PLSW_IDLE;
			cnt_q <= '0;
		end else if (start) begin
			state_q <= PLSW_COUNT; // Restart from zero [RL15]
			cnt_q <= '0;
		end else begin
			case (state_q)
				PLSW_COUNT: begin
					if (rc_tick) begin
						if (cnt_q + 17'h00001 >= wait_len(wait_sel)) begin
							state_q <= PLSW_DONE; // [RL2] [RL15]
						end
						cnt_q <= cnt_q + 17'h00001;
					end
				end
				default: begin
					state_q <= state_q;
				end
			endcase
		end
	end

	// One-cycle completion event
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			done_q <= 1'b0;
		end else begin
			done_q <= !soft_clr && enable && !start && rc_tick &&
				(state_q == PLSW_COUNT) &&
				(cnt_q + 17'h00001 >= wait_len(wait_sel));
		end
	end

	assign done_pulse = done_q;
	assign stable = (state_q == PLSW_DONE);
endmodule // plsw_wait_timer
`default_nettype wire
